/* rtl/idp_consts.svh */
/*
 * constants of the identification page slave: select code, field
 * positions, erased values. assumes inclusion by idp_pkg and the slave.
 */
`ifndef IDP_CONSTS_SVH
`define IDP_CONSTS_SVH
`define IDP_DEV_TYPE 4'hb
`define IDP_PAGE_BYTES 64
`define IDP_OFS_W 6
`define IDP_LOCK_SEL_POS 2
`define IDP_LOCK_DATA_POS 1
`define IDP_ERASED 8'hff
`define IDP_WAFER_LAST 8'h22
`define IDP_BYTE_END 4'h8
`endif

/* rtl/idp_pkg.sv */
/*
 * types of the identification page slave.
 * assumes idp_consts.svh sits beside it.
 */
`include "idp_consts.svh"
package idp_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_AHI,
        ST_ALO,
        ST_WDAT,
        ST_RDAT
    } idp_state_t;
    typedef logic [`IDP_OFS_W-1:0] idp_ofs_t;
endpackage

/* rtl/idp_id_page.sv */
/*
 * two-wire slave for the 64-byte identification page: page read, page
 * write, lock command and lock status probe.
 * assumes scl and sda arrive asynchronously and are sampled by clk_i,
 * scl far slower than clk_i; sda is open drain, resolved outside.
 */
// Summary of operation
// - a 64-byte identification page can be written and then locked until the next reset.
// - page access uses the random read sequence with device type 1011b.
// - upper address bits other than bit 10 (lock select) are ignored and the six low bits give the offset.
// - the probe data byte is acknowledged if unlocked, refused if locked.
// - a start clears the command logic and drops any pending write.
// - a stop after the aborted probe returns the slave to standby.
// - erased page bytes read as all ones.
// - on wafer delivery the last main array byte holds 22h.
// - a write cycle begins only on a decoded page write or lock command.
// - when locked every page write data byte is refused, page unchanged.
// - a page access loads the shared address counter with the offset.
`timescale 1ns/1ps
`include "idp_consts.svh"
module idp_id_page (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [2:0] chip_en_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    output logic id_locked_o,
    output logic wr_cycle_o,
    output idp_pkg::idp_ofs_t addr_o
);
    import idp_pkg::*;

    logic [1:0] scl_sy, sda_sy;
    logic [2:0] ce_a, ce_b;
    logic scl_d, sda_d;
    logic scl_rise, scl_fall, start_det, stop_det;
    idp_state_t st;
    logic [3:0] cnt;
    logic ack_phase;
    logic [7:0] shift, rdata;
    idp_ofs_t ofs;
    logic lock_sel, locked, lock_pend, wr_pend;
    logic [7:0] mem [0:`IDP_PAGE_BYTES-1];
    logic [7:0] stage [0:`IDP_PAGE_BYTES-1];
    logic [`IDP_PAGE_BYTES-1:0] stage_mask, prog_mask;
    logic byte_end, dev_ok, commit;

    // erased bytes show all ones; main array wafer value lives outside
    function automatic logic [7:0] page_byte(input idp_ofs_t o);
        page_byte = prog_mask[o] ? mem[o] : `IDP_ERASED;
    endfunction

    // pin synchronisers
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scl_sy <= 2'h3;
            sda_sy <= 2'h3;
            ce_a <= 3'h0;
            ce_b <= 3'h0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_sy <= {scl_sy[0], scl_i};
            sda_sy <= {sda_sy[0], sda_i};
            ce_a <= chip_en_i;
            ce_b <= ce_a;
            scl_d <= scl_sy[1];
            sda_d <= sda_sy[1];
        end
    end

    assign scl_rise = scl_sy[1] && !scl_d;
    assign scl_fall = !scl_sy[1] && scl_d;
    assign start_det = scl_sy[1] && scl_d && sda_d && !sda_sy[1];
    assign stop_det = scl_sy[1] && scl_d && !sda_d && sda_sy[1];
    assign byte_end = scl_fall && !ack_phase && cnt == `IDP_BYTE_END;
    assign dev_ok = shift[7:4] == `IDP_DEV_TYPE && shift[3:1] == ce_b;
    assign commit = stop_det && st == ST_WDAT && (wr_pend || lock_pend);

    // bit engine and command decoding
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= ST_IDLE;
            cnt <= 4'h0;
            ack_phase <= 1'b0;
            shift <= 8'h0;
            rdata <= 8'h0;
            ofs <= '0;
            lock_sel <= 1'b0;
            lock_pend <= 1'b0;
            wr_pend <= 1'b0;
            stage_mask <= '0;
            sda_oe_n_o <= 1'b1;
        end else if (start_det) begin
            st <= ST_DEV;
            cnt <= 4'h0;
            ack_phase <= 1'b0;
            lock_pend <= 1'b0;
            wr_pend <= 1'b0;
            stage_mask <= '0;
            sda_oe_n_o <= 1'b1;
        end else if (stop_det) begin
            st <= ST_IDLE;
            ack_phase <= 1'b0;
            lock_pend <= 1'b0;
            wr_pend <= 1'b0;
            stage_mask <= '0;
            sda_oe_n_o <= 1'b1;
        end else if (st == ST_IDLE) begin
            sda_oe_n_o <= 1'b1;
        end else if (scl_rise) begin
            if (!ack_phase && cnt < `IDP_BYTE_END) begin
                shift <= {shift[6:0], sda_sy[1]};
                cnt <= cnt + 4'h1;
            end else if (ack_phase && st == ST_RDAT && sda_oe_n_o) begin
                if (sda_sy[1]) begin
                    st <= ST_IDLE;
                end else begin
                    ofs <= ofs + 1'b1;
                    rdata <= page_byte(ofs + 1'b1);
                end
            end
        end else if (scl_fall) begin
            if (ack_phase) begin
                ack_phase <= 1'b0;
                cnt <= 4'h0;
                sda_oe_n_o <= (st == ST_RDAT) ? rdata[7] : 1'b1;
            end else if (cnt == `IDP_BYTE_END) begin
                ack_phase <= 1'b1;
                sda_oe_n_o <= 1'b1;
                case (st)
                    ST_DEV: begin
                        if (!dev_ok) begin
                            st <= ST_IDLE;
                        end else if (shift[0]) begin
                            st <= ST_RDAT;
                            rdata <= page_byte(ofs);
                            sda_oe_n_o <= 1'b0;
                        end else begin
                            st <= ST_AHI;
                            sda_oe_n_o <= 1'b0;
                        end
                    end
                    ST_AHI: begin
                        lock_sel <= shift[`IDP_LOCK_SEL_POS];
                        st <= ST_ALO;
                        sda_oe_n_o <= 1'b0;
                    end
                    ST_ALO: begin
                        ofs <= shift[`IDP_OFS_W-1:0];
                        st <= ST_WDAT;
                        sda_oe_n_o <= 1'b0;
                    end
                    ST_WDAT: begin
                        if (!locked) begin
                            sda_oe_n_o <= 1'b0;
                            if (lock_sel) begin
                                lock_pend <= shift[`IDP_LOCK_DATA_POS];
                            end else begin
                                stage_mask[ofs] <= 1'b1;
                                wr_pend <= 1'b1;
                                ofs <= ofs + 1'b1;
                            end
                        end
                    end
                    default: begin
                        sda_oe_n_o <= 1'b1;
                    end
                endcase
            end else if (st == ST_RDAT) begin
                sda_oe_n_o <= rdata[3'h7 - cnt[2:0]];
            end
        end
    end

    // staged write data, kept until the closing stop
    always_ff @(posedge clk_i) begin
        if (byte_end && st == ST_WDAT && !locked && !lock_sel) begin
            stage[ofs] <= shift;
        end
    end

    // page contents, updated only by a committed write cycle
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < `IDP_PAGE_BYTES; i++) begin
            if (commit && !locked && stage_mask[i]) begin
                mem[i] <= stage[i];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prog_mask <= '0;
            locked <= 1'b0;
            wr_cycle_o <= 1'b0;
        end else begin
            wr_cycle_o <= commit;
            if (commit && !locked) begin
                prog_mask <= prog_mask | stage_mask;
                if (lock_pend) begin
                    locked <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sda_o <= 1'b0;
            id_locked_o <= 1'b0;
            addr_o <= '0;
        end else begin
            sda_o <= 1'b0;
            id_locked_o <= locked;
            addr_o <= ofs;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    sequence data_byte_s;
        byte_end ##0 st == ST_WDAT;
    endsequence
    sequence read_ack_s;
        scl_rise && ack_phase && st == ST_RDAT && !sda_sy[1] && sda_oe_n_o;
    endsequence
    sequence read_sel_s;
        scl_rise && ack_phase && st == ST_RDAT && !sda_oe_n_o;
    endsequence

    start_clears_a: assert property (start_det |=> st == ST_DEV &&
        !wr_pend && !lock_pend && stage_mask == '0 && sda_oe_n_o)
        else $error("start did not clear command logic");
    stop_standby_a: assert property (stop_det |=> st == ST_IDLE)
        else $error("stop did not return to standby");
    write_decoded_a: assert property (wr_cycle_o |->
        $past(stop_det) && $past(st) == ST_WDAT)
        else $error("write cycle without decoded write");
    locked_nack_a: assert property (data_byte_s ##0 locked |=>
        sda_oe_n_o && stage_mask == $past(stage_mask))
        else $error("locked page accepted data");
    probe_ack_a: assert property (data_byte_s ##0 !locked |=>
        !sda_oe_n_o ##1 !sda_oe_n_o)
        else $error("unlocked probe not acknowledged");
    type_check_a: assert property (byte_end && st == ST_DEV &&
        shift[7:4] != `IDP_DEV_TYPE |=> st == ST_IDLE && sda_oe_n_o)
        else $error("foreign device type acknowledged");
    offset_load_a: assert property (byte_end && st == ST_ALO |=>
        ofs == $past(shift[5:0]) ##1 addr_o == $past(ofs))
        else $error("address counter not loaded with offset");
    read_step_a: assert property (read_ack_s |=>
        ofs == $past(ofs) + 6'h1 && rdata == page_byte(ofs))
        else $error("read offset did not step");
    select_ack_a: assert property (read_sel_s |=> ofs == $past(ofs))
        else $error("select ack stepped the offset");
    lock_kept_a: assert property (id_locked_o |=> id_locked_o)
        else $error("lock was lost");
    erased_read_a: assert property (byte_end && st == ST_DEV &&
        dev_ok && shift[0] && !prog_mask[ofs] |=> rdata == `IDP_ERASED)
        else $error("erased byte not all ones");
endmodule

/* test/idp_master.sv */
/*
 * two-wire bus master model: drives scl, pulls sda low, reports acks and
 * read bytes. assumes sda is resolved outside with a pull-up.
 */
`timescale 1ns/1ps
`include "idp_consts.svh"
module idp_master (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o,
    output logic res_v_o,
    output logic [8:0] res_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
        res_v_o = 1'b0;
        res_o = 9'h000;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic put(input logic [8:0] v);
        res_o = v;
        res_v_o = 1'b1;
        tick(1);
        res_v_o = 1'b0;
    endtask
    // one bus clock of 8 cycles: 5 low, 3 high
    task automatic bit_x(input logic b, output logic s);
        scl_o = 1'b0;
        tick(1);
        sda_low_o = ~b;
        tick(4);
        scl_o = 1'b1;
        tick(1);
        s = sda_i;
        tick(2);
        scl_o = 1'b0;
    endtask
    task automatic start();
        tick(1);
        sda_low_o = 1'b0;
        tick(5);
        scl_o = 1'b1;
        tick(3);
        sda_low_o = 1'b1;
        tick(3);
        scl_o = 1'b0;
    endtask
    task automatic stop();
        tick(1);
        sda_low_o = 1'b1;
        tick(4);
        scl_o = 1'b1;
        tick(3);
        sda_low_o = 1'b0;
        tick(4);
    endtask
    task automatic wbyte(input logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(d[i], s);
        bit_x(1'b1, s);
        put({1'b1, 7'h00, s});
    endtask
    task automatic rbyte(input logic last);
        logic [7:0] d;
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(last, s); // nack on the last byte
        put({1'b0, d});
    endtask
    // dummy write of the address, restart, read
    task automatic id_read(input logic [15:0] a, input logic [2:0] ce,
                           input int n);
        start();
        wbyte({`IDP_DEV_TYPE, ce, 1'b0});
        wbyte(a[15:8]);
        wbyte(a[7:0]);
        start();
        wbyte({`IDP_DEV_TYPE, ce, 1'b1});
        for (int i = 0; i < n; i++) rbyte(i == n - 1);
        stop();
    endtask
    // current address read from the shared counter
    task automatic cur_read(input logic [2:0] ce, input int n);
        start();
        wbyte({`IDP_DEV_TYPE, ce, 1'b1});
        for (int i = 0; i < n; i++) rbyte(i == n - 1);
        stop();
    endtask
    // a probe is one data byte then start and stop
    task automatic id_write(input logic [15:0] a, input logic [2:0] ce,
                            input logic [7:0] d[$], input logic probe);
        start();
        wbyte({`IDP_DEV_TYPE, ce, 1'b0});
        wbyte(a[15:8]);
        wbyte(a[7:0]);
        foreach (d[i]) wbyte(d[i]);
        if (probe) start();
        stop();
    endtask
endmodule

/* test/idp_id_page_test.sv */
/*
 * self-checking bench of the identification page slave.
 * assumes idp_pkg, idp_id_page and idp_master are compiled first.
 */
`timescale 1ns/1ps
module idp_id_page_test;
    import idp_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [2:0] chip_en_i = 3'h0;
    logic scl, m_low, sda_o, sda_oe_n_o, id_locked_o, wr_cycle_o, res_v;
    logic [8:0] res;
    idp_ofs_t addr_o, o;
    wire sda = ~m_low & (sda_oe_n_o | sda_o);
    logic [8:0] q[$];
    logic [7:0] page[64];
    logic [31:0] r;
    logic locked;
    integer seed, errors = 0, tests_run = 0, wrc = 0, cyc = 0;
    idp_id_page dut (.clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl),
        .sda_i(sda), .chip_en_i(chip_en_i), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n_o), .id_locked_o(id_locked_o),
        .wr_cycle_o(wr_cycle_o), .addr_o(addr_o));
    idp_master m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl),
        .sda_low_o(m_low), .res_v_o(res_v), .res_o(res));
    always #50 clk_i = ~clk_i;
    task automatic conclude();
        $display("checks %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] s);
        tests_run++;
        if (e !== s) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (wr_cycle_o === 1'b1) wrc++;
        if (res_v === 1'b1) begin
            chk("bus result", q.size() ? q.pop_front() : 'x, res);
        end
        if (cyc == 20000) begin
            errors++;
            conclude();
        end
    end
    task automatic rd(input idp_ofs_t o, input int n);
        logic [15:0] a;
        a = $random(seed);
        a[5:0] = o; // upper bits random
        repeat (4) q.push_back(9'h100);
        for (int i = 0; i < n; i++) begin
            q.push_back({1'b0, page[o + i]});
        end
        m.id_read(a, chip_en_i, n);
    endtask
    task automatic crd(input idp_ofs_t o, input int n);
        q.push_back(9'h100);
        for (int i = 0; i < n; i++) begin
            q.push_back({1'b0, page[o + i]});
        end
        m.cur_read(chip_en_i, n);
    endtask
    task automatic wr(input idp_ofs_t o, input logic lk, input int n,
                      input logic probe);
        logic [15:0] a;
        logic [7:0] d[$];
        logic [31:0] v;
        idp_ofs_t p;
        a = $random(seed);
        a[10] = lk;
        a[5:0] = o;
        p = o;
        repeat (3) q.push_back(9'h100);
        for (int i = 0; i < n; i++) begin
            v = $random(seed);
            d.push_back(v[7:0] | {6'h00, lk, 1'b0});
            q.push_back({1'b1, 7'h00, locked});
            if (!locked && !lk && !probe) page[p] = d[i];
            p = p + 1'b1;
        end
        m.id_write(a, chip_en_i, d, probe);
        m.tick(2);
    endtask
    initial begin
        seed = 49;
        locked = 1'b0;
        foreach (page[i]) page[i] = 8'hff;
        r = $random(seed);
        chip_en_i = r[2:0];
        repeat (16) @(posedge clk_i);
        #1 rstn_i = 1'b1;
        m.tick(4);
        r = $random(seed);
        o = (r[5:0] > 6'd61) ? 6'd61 : r[5:0]; // ends inside page
        rd(o, 3);
        $display("test erased read done");
        wr(6'd62, 1'b0, 2, 1'b0);
        chk("write cycles", 1, wrc);
        chk("address", 0, {26'h0, addr_o});
        rd(6'd62, 2);
        $display("test page write done");
        wr(6'd62, 1'b0, 1, 1'b1);
        chk("write cycles", 1, wrc);
        rd(6'd62, 1);
        $display("test open probe done");
        wr(6'd61, 1'b0, 1, 1'b0);
        crd(6'd62, 2);
        $display("test current read done");
        q.push_back(9'h101);
        m.start();
        m.wbyte({4'ha, chip_en_i, 1'b0});
        m.stop();
        q.push_back(9'h101);
        m.start();
        m.wbyte({4'hb, ~chip_en_i, 1'b0});
        m.stop();
        $display("test refused select done");
        wr(6'd0, 1'b1, 1, 1'b0);
        locked = 1'b1;
        chk("write cycles", 3, wrc);
        chk("locked", 1, {31'h0, id_locked_o});
        wr(o, 1'b0, 1, 1'b1);
        wr(6'd62, 1'b0, 2, 1'b0);
        chk("write cycles", 3, wrc);
        rd(6'd62, 2);
        $display("test locked page done");
        r = $random(seed);
        rstn_i = 1'b0;
        chip_en_i = chip_en_i ^ {r[2:1], 1'b1};
        m.tick(3);
        rstn_i = 1'b1;
        locked = 1'b0;
        foreach (page[i]) page[i] = 8'hff;
        m.tick(4);
        chk("locked", 0, {31'h0, id_locked_o});
        chk("drive level", 0, {31'h0, sda_o});
        rd(6'd62, 2);
        wr(6'd0, 1'b0, 1, 1'b1);
        $display("test reset done");
        chk("pending results", 0, q.size());
        conclude();
    end
endmodule
